// File: src/rpts_dev.sv
// module: controller end, reset sequencing, parking and strap sampling
`timescale 1ns/1ps
module rpts_dev #(
	parameter int unsigned STRAP_CYCLES  = rpts_pkg::STRAP_CYC,
	parameter int unsigned INIT_CYCLES   = rpts_pkg::INIT_CYC,
	parameter int unsigned NPARK_CYCLES  = rpts_pkg::NORMAL_PARK_CYC
) (
	// clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           srst_i,
	// pins
	rpts_if.dev                                 pins,
	// user side
	input  wire logic                           stream_mode_i,
	input  wire logic                           trig_out_i,
	input  wire logic [1:0]                     light_sel_i,
	input  wire logic [rpts_pkg::NUM_GPIO-1:0]  gpio_out_i,
	input  wire logic [rpts_pkg::NUM_GPIO-1:0]  gpio_oe_i,
	input  wire logic [3:0]                     flash_i,
	output logic [rpts_pkg::NUM_STRAP-1:0]      test_mode_select_o,
	output logic                                test_mode_o,
	output logic                                trigger_input_o,
	output logic                                running_o,
	output logic                                parked_o,
	output logic [rpts_pkg::NUM_GPIO-1:0]       gpio_in_o
);
	import rpts_pkg::*;

	rpts_state_t        state;
	rpts_state_t        next_state;
	logic [2:0]         rst_sync;
	logic [2:0]         fpark_sync;
	logic [2:0]         npark_sync;
	logic [2:0]         eye_sync;
	logic               rst_q;
	logic               fpark_q;
	logic               npark_q;
	logic               rst_rise;
	logic [CNT_W-1:0]   cnt;
	logic               cnt_done;
	logic               npark_busy;
	logic [CNT_W-1:0]   npark_cnt;
	logic [NUM_STRAP-1:0] strap_s1;
	logic [NUM_STRAP-1:0] strap_s2;
	logic [NUM_STRAP-1:0] strap_s3;
	logic [NUM_GPIO-1:0]  gpio_s1;
	logic [NUM_GPIO-1:0]  gpio_s2;
	logic [NUM_GPIO-1:0]  gpio_s3;
	logic [NUM_GPIO-1:0]  gpio_agree;

	// three stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst_sync   <= 3'h0;
			fpark_sync <= 3'h0;
			npark_sync <= 3'h7;
			eye_sync   <= 3'h0;
		end else begin
			rst_sync   <= {rst_sync[1:0], pins.power_on_reset_in_n}; // see RULE_15
			fpark_sync <= {fpark_sync[1:0], pins.fast_mirror_park_n}; // see RULE_15
			npark_sync <= {npark_sync[1:0], pins.gpio_in[NORMAL_PARK_GPIO]};
			eye_sync   <= {eye_sync[1:0], pins.stereo_eye_select};
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst_q   <= 1'b0;
			fpark_q <= 1'b0;
			npark_q <= 1'b1;
		end else begin
			if (rst_sync[2] == rst_sync[1])
				rst_q <= rst_sync[2];
			if (fpark_sync[2] == fpark_sync[1])
				fpark_q <= fpark_sync[2];
			if (npark_sync[2] == npark_sync[1])
				npark_q <= npark_sync[2];
		end
	end

	// straps and gpio are pins too, so they pass the same three stages
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			strap_s1 <= '0;
			strap_s2 <= '0;
			strap_s3 <= '0;
			gpio_s1  <= '0;
			gpio_s2  <= '0;
			gpio_s3  <= '0;
		end else begin
			strap_s1 <= pins.strap_in;
			strap_s2 <= strap_s1;
			strap_s3 <= strap_s2;
			gpio_s1  <= pins.gpio_in;
			gpio_s2  <= gpio_s1;
			gpio_s3  <= gpio_s2;
		end
	end

	assign gpio_agree = ~(gpio_s2 ^ gpio_s3);
	assign rst_rise = !rst_q && (rst_sync[2] == rst_sync[1]) && rst_sync[2];
	assign cnt_done = (cnt == '0);

	always_comb begin
		next_state = state;
		unique case (state)
			RPTS_RESET:    if (rst_rise) next_state = RPTS_STRAP; // see RULE_01
			RPTS_STRAP:    if (cnt_done) next_state = RPTS_INIT; // see RULE_08
			RPTS_INIT:     if (cnt_done) next_state = RPTS_RUN;
			RPTS_RUN:      if (!fpark_q) next_state = RPTS_FASTPARK; // see RULE_06
			RPTS_FASTPARK: if (cnt_done) next_state = RPTS_PARKED;
			RPTS_PARKED:   if (fpark_q) next_state = RPTS_INIT;
		endcase
		if (!rst_q && !rst_rise)
			next_state = RPTS_RESET;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i)
			state <= RPTS_RESET;
		else
			state <= next_state;
	end

	// phase timer, loaded on each state entry
	always_ff @(posedge clk_i) begin
		if (srst_i)
			cnt <= '0;
		else if (next_state != state) begin
			unique case (next_state)
				RPTS_STRAP:    cnt <= CNT_W'(STRAP_CYCLES - 1);
				RPTS_INIT:     cnt <= CNT_W'(INIT_CYCLES - 1);
				RPTS_FASTPARK: cnt <= CNT_W'(FAST_PARK_CYC - 1); // see RULE_06
				default:       cnt <= '0;
			endcase
		end else if (!cnt_done)
			cnt <= cnt - 1'b1;
	end

	// normal park takes the full slow interval; the mirrors stay parked after
	always_ff @(posedge clk_i) begin
		if (srst_i || state == RPTS_RESET) begin
			npark_busy <= 1'b0;
			npark_cnt  <= '0;
		end else if (state == RPTS_RUN && !npark_q && !npark_busy) begin
			npark_busy <= 1'b1; // see RULE_07
			npark_cnt  <= CNT_W'(NPARK_CYCLES - 1);
		end else if (npark_busy && npark_cnt != '0)
			npark_cnt <= npark_cnt - 1'b1;
	end

	// straps caught once, at the end of the sampling interval
	// a strap counts high only when both stages agree; an unsettled pin means normal
	always_ff @(posedge clk_i) begin
		if (srst_i)
			test_mode_select_o <= '0;
		else if (state == RPTS_STRAP && cnt_done)
			test_mode_select_o <= strap_s3 & strap_s2; // see RULE_08
	end

	always_ff @(posedge clk_i) begin
		if (srst_i)
			test_mode_o <= 1'b0;
		else if (state == RPTS_STRAP && cnt_done)
			test_mode_o <= |(strap_s3 & strap_s2); // see RULE_09
	end

	logic out_live;
	logic mirrors_on;
	assign out_live   = (state != RPTS_RESET) && (next_state != RPTS_RESET);
	assign mirrors_on = (next_state == RPTS_RUN) && !(npark_busy && npark_cnt == '0);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pins.gpio_oe          <= '0;
			pins.gpio_out         <= '0;
			pins.serial_flash_oe  <= 1'b0;
			pins.serial_flash_clock    <= 1'b0;
			pins.serial_flash_data_out <= 1'b0;
			pins.serial_flash_select_0 <= 1'b0;
			pins.serial_flash_select_1 <= 1'b0;
			pins.strap_oe         <= '0;
			pins.strap_out        <= '0;
			pins.light_source_select_0 <= 1'b0;
			pins.light_source_select_1 <= 1'b0;
			pins.mirror_driver_enable  <= 1'b0;
			pins.host_irq_oe      <= 1'b0;
			pins.host_irq_out     <= 1'b0;
		end else begin
			// park request pin stays an input whatever the user asks
			pins.gpio_oe  <= out_live ? (gpio_oe_i & ~(NUM_GPIO'(1) << NORMAL_PARK_GPIO))
				: '0; // see RULE_02
			pins.gpio_out <= out_live ? gpio_out_i : '0;
			pins.serial_flash_oe       <= out_live; // see RULE_02
			pins.serial_flash_clock    <= out_live & flash_i[0];
			pins.serial_flash_data_out <= out_live & flash_i[1];
			pins.serial_flash_select_0 <= !out_live | flash_i[2];
			pins.serial_flash_select_1 <= !out_live | flash_i[3];
			// straps float until sampled, then drive; pin 4 carries the trigger
			pins.strap_oe  <= (out_live && state != RPTS_STRAP) ? '1 : '0; // see RULE_08
			pins.strap_out <= '0;
			pins.strap_out[TRIG_STRAP] <= out_live && state != RPTS_STRAP
				&& trig_out_i; // see RULE_10
			// light selects and mirror enable forced low outside running
			pins.light_source_select_0 <= mirrors_on & light_sel_i[0]; // see RULE_03
			pins.light_source_select_1 <= mirrors_on & light_sel_i[1]; // see RULE_03
			pins.mirror_driver_enable  <= mirrors_on; // see RULE_03
			// irq active low: low while busy initialising, high once running
			pins.host_irq_oe  <= out_live; // see RULE_14
			pins.host_irq_out <= (next_state == RPTS_RUN);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			trigger_input_o <= 1'b0;
			running_o       <= 1'b0;
			parked_o        <= 1'b1;
			gpio_in_o       <= '0;
		end else begin
			// the third stage is taken once the second agrees, never the first
			trigger_input_o <= stream_mode_i && (eye_sync[2] == eye_sync[1])
				? eye_sync[2] : trigger_input_o & stream_mode_i; // see RULE_12
			running_o       <= mirrors_on;
			parked_o        <= !mirrors_on;
			gpio_in_o       <= (gpio_in_o & ~gpio_agree) | (gpio_s3 & gpio_agree);
		end
	end
endmodule

// File: src/rpts_host.sv
// module: host and power manager end, drives reset, park and eye reference
`timescale 1ns/1ps
module rpts_host #(
	parameter int unsigned QUIET_CYCLES = rpts_pkg::I2C_QUIET_CYC,
	parameter int unsigned FPARK_CYCLES = rpts_pkg::FAST_PARK_CYC
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// pins
	rpts_if.host      pins,
	// user side
	input  wire logic power_good_i,
	input  wire logic power_fail_i,
	input  wire logic eye_left_i,
	input  wire logic eye_load_i,
	output logic      i2c_allowed_o,
	output logic      power_off_ok_o
);
	import rpts_pkg::*;

	logic [CNT_W-1:0] quiet_cnt;
	logic [CNT_W-1:0] park_cnt;
	logic             fpark_n;

	// park raised one cycle before reset is released
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fpark_n                        <= 1'b0;
			pins.fast_mirror_park_n        <= 1'b0;
			pins.power_on_reset_in_n       <= 1'b0;
			pins.manufacturing_test_enable <= 1'b0; // see RULE_11
		end else begin
			fpark_n                        <= power_good_i && !power_fail_i;
			pins.fast_mirror_park_n        <= power_good_i && !power_fail_i; // see RULE_05
			// once released, reset holds through a fast park; only power loss drops it
			pins.power_on_reset_in_n       <= power_good_i && // see RULE_05
				(pins.power_on_reset_in_n || fpark_n); // see RULE_06
			pins.manufacturing_test_enable <= 1'b0;
		end
	end

	// eye reference loads only when the user marks mid frame
	always_ff @(posedge clk_i) begin
		if (srst_i)
			pins.stereo_eye_select <= 1'b0;
		else if (eye_load_i)
			pins.stereo_eye_select <= eye_left_i; // see RULE_13
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !pins.power_on_reset_in_n || !pins.fast_mirror_park_n) begin
			quiet_cnt     <= CNT_W'(QUIET_CYCLES);
			i2c_allowed_o <= 1'b0;
		end else if (quiet_cnt != '0) begin
			quiet_cnt     <= quiet_cnt - 1'b1;
			i2c_allowed_o <= 1'b0;
		end else
			i2c_allowed_o <= 1'b1; // see RULE_04
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || pins.fast_mirror_park_n) begin
			park_cnt       <= CNT_W'(FPARK_CYCLES + 1);
			power_off_ok_o <= 1'b0;
		end else if (park_cnt != '0) begin
			park_cnt       <= park_cnt - 1'b1;
			power_off_ok_o <= 1'b0;
		end else
			power_off_ok_o <= 1'b1; // see RULE_06
	end
endmodule

// File: src/rpts_if.sv
// interface: pins between the controller and host / power manager
`timescale 1ns/1ps
interface rpts_if;
	import rpts_pkg::*;
	logic                 power_on_reset_in_n;
	logic                 fast_mirror_park_n;
	logic                 manufacturing_test_enable;
	logic                 stereo_eye_select;
	logic [NUM_GPIO-1:0]  gpio_in;
	logic [NUM_GPIO-1:0]  gpio_out;
	logic [NUM_GPIO-1:0]  gpio_oe;
	logic [NUM_STRAP-1:0] strap_in;
	logic [NUM_STRAP-1:0] strap_out;
	logic [NUM_STRAP-1:0] strap_oe;
	logic                 serial_flash_clock;
	logic                 serial_flash_data_out;
	logic                 serial_flash_select_0;
	logic                 serial_flash_select_1;
	logic                 serial_flash_oe;
	logic                 light_source_select_0;
	logic                 light_source_select_1;
	logic                 mirror_driver_enable;
	logic                 host_irq_out;
	logic                 host_irq_oe;

	modport dev (
		input  power_on_reset_in_n, fast_mirror_park_n, manufacturing_test_enable,
		input  stereo_eye_select, gpio_in, strap_in,
		output gpio_out, gpio_oe, strap_out, strap_oe,
		output serial_flash_clock, serial_flash_data_out, serial_flash_select_0,
		output serial_flash_select_1, serial_flash_oe,
		output light_source_select_0, light_source_select_1, mirror_driver_enable,
		output host_irq_out, host_irq_oe
	);
	modport host (
		output power_on_reset_in_n, fast_mirror_park_n, manufacturing_test_enable,
		output stereo_eye_select,
		input  gpio_out, gpio_oe, strap_out, strap_oe,
		input  light_source_select_0, light_source_select_1, mirror_driver_enable,
		input  host_irq_out, host_irq_oe
	);
endinterface

// File: src/rpts_pkg.sv
// package: constants and types for the reset, park and strap controller
//
// Behaviour
// RULE_01: reset rising edge starts self configuration
// RULE_02: flash pins and gpio float during reset
// RULE_03: light selects and mirror enable low in reset
// RULE_04: host waits 500 ms before control traffic
// RULE_05: host raises fast park before releasing reset
// RULE_06: fast park low 32 us before power off
// RULE_07: normal park request on gpio 8, 20 ms
// RULE_08: straps float in reset, sampled 1.5 us later
// RULE_09: high strap selects test mode, open is normal
// RULE_10: strap pin 4 becomes first trigger output
// RULE_11: board ties manufacturing test enable low
// RULE_12: stereo eye select is trigger input, streaming only
// RULE_13: host changes eye reference mid frame
// RULE_14: host interrupt shows init busy, floats in reset
// RULE_15: synchronise reset and park inputs first
package rpts_pkg;
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned NUM_GPIO      = 20;
	localparam int unsigned NUM_STRAP     = 8;
	localparam int unsigned NORMAL_PARK_GPIO = 8;
	localparam int unsigned TRIG_STRAP    = 4;
	// times in their own units
	localparam int unsigned STRAP_NS      = 1500;
	localparam int unsigned FAST_PARK_US  = 32;
	localparam int unsigned NORMAL_PARK_MS = 20;
	localparam int unsigned I2C_QUIET_MS  = 500;
	localparam int unsigned INIT_US       = 100;
	// derived cycle counts
	localparam int unsigned STRAP_CYC     = (STRAP_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned FAST_PARK_CYC = (FAST_PARK_US * (CLK_HZ / 1_000_000)) - 1;
	localparam int unsigned NORMAL_PARK_CYC = NORMAL_PARK_MS * (CLK_HZ / 1000);
	localparam int unsigned I2C_QUIET_CYC = I2C_QUIET_MS * (CLK_HZ / 1000);
	localparam int unsigned INIT_CYC      = INIT_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W         = 24;
	localparam logic [1:0]  LSEL_NONE     = 2'h0;

	typedef enum logic [5:0] {
		RPTS_RESET    = 6'b00_0001,
		RPTS_STRAP    = 6'b00_0010,
		RPTS_INIT     = 6'b00_0100,
		RPTS_RUN      = 6'b00_1000,
		RPTS_FASTPARK = 6'b01_0000,
		RPTS_PARKED   = 6'b10_0000
	} rpts_state_t;
endpackage

// File: verif/rpts_sva.sv
// checker: pin level rules across the reset and park link
`timescale 1ns/1ps
module rpts_sva (
	// clock and reset
	input wire logic                           clk_i,
	input wire logic                           srst_i,
	// link pins
	input wire logic                           power_on_reset_in_n,
	input wire logic                           fast_mirror_park_n,
	input wire logic                           manufacturing_test_enable,
	input wire logic [rpts_pkg::NUM_GPIO-1:0]  gpio_in,
	input wire logic [rpts_pkg::NUM_GPIO-1:0]  gpio_oe,
	input wire logic [rpts_pkg::NUM_STRAP-1:0] strap_oe,
	input wire logic                           serial_flash_oe,
	input wire logic                           light_source_select_0,
	input wire logic                           light_source_select_1,
	input wire logic                           mirror_driver_enable,
	input wire logic                           host_irq_oe
);
	import rpts_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// six low cycles cover the input sync, the level latch and the output register
	AST_RST_FLOAT: assert property (
		!power_on_reset_in_n [*6] |-> !serial_flash_oe && gpio_oe == '0) else $error("float");
	AST_RST_LOW: assert property (
		!power_on_reset_in_n [*6] |-> !light_source_select_0 && !light_source_select_1
		&& !mirror_driver_enable) else $error("low in reset");
	AST_IRQ_FLOAT: assert property (
		!power_on_reset_in_n [*6] |-> !host_irq_oe) else $error("irq float");
	AST_INIT: assert property (
		$rose(power_on_reset_in_n) |-> !mirror_driver_enable [*8] ##[4:32]
		mirror_driver_enable) else $error("init");
	AST_STRAP: assert property (
		$rose(power_on_reset_in_n) |-> (strap_oe == '0) [*6] ##[1:20]
		(strap_oe == '1)) else $error("strap");
	AST_FPARK: assert property (
		$fell(fast_mirror_park_n) && power_on_reset_in_n |-> ##[1:5] !mirror_driver_enable
		&& !light_source_select_0 && !light_source_select_1) else $error("fast park");
	// the slow park must not cut the mirrors at once
	AST_NPARK: assert property (
		$fell(gpio_in[8]) && mirror_driver_enable |-> mirror_driver_enable [*8] ##[8:22]
		!mirror_driver_enable) else $error("normal park");
	AST_PARK_IN: assert property (!gpio_oe[8]) else $error("gpio 8 driven");
	AST_ORDER: assert property (
		$rose(power_on_reset_in_n) |-> $past(fast_mirror_park_n)) else $error("order");
	AST_TEST_EN: assert property (
		manufacturing_test_enable == 1'b0) else $error("test enable");
endmodule

// File: verif/tb_top.sv
// testbench: host and controller ends joined, driven from their user sides
`timescale 1ns/1ps
module tb_top;
	import rpts_pkg::*;
	logic                 clk_i;
	logic                 srst_i;
	logic                 pg;
	logic                 pf;
	logic                 eye_l;
	logic                 eye_ld;
	logic                 strm;
	logic                 trg;
	logic [1:0]           lsel;
	logic [NUM_GPIO-1:0]  gout;
	logic [NUM_GPIO-1:0]  goe;
	logic [NUM_GPIO-1:0]  gpio_brd;
	logic [3:0]           flash;
	logic [NUM_STRAP-1:0] strap_brd;
	logic [NUM_STRAP-1:0] tms;
	logic                 tm;
	logic                 tin;
	logic                 run;
	logic                 prk;
	logic                 i2c;
	logic                 poff;
	logic [NUM_GPIO-1:0]  gin;
	int                   errors = 0;
	int                   checks_done = 0;

	rpts_if ifc ();
	// board side: pads show the driver when enabled, else the board level
	assign ifc.gpio_in  = (ifc.gpio_oe & ifc.gpio_out) | (~ifc.gpio_oe & gpio_brd);
	assign ifc.strap_in = (ifc.strap_oe & ifc.strap_out) | (~ifc.strap_oe & strap_brd);

	rpts_dev #(.STRAP_CYCLES(4), .INIT_CYCLES(8), .NPARK_CYCLES(20)) u_rpts_dev (
		.clk_i(clk_i), .srst_i(srst_i), .pins(ifc.dev), .stream_mode_i(strm),
		.trig_out_i(trg), .light_sel_i(lsel), .gpio_out_i(gout), .gpio_oe_i(goe),
		.flash_i(flash), .test_mode_select_o(tms), .test_mode_o(tm),
		.trigger_input_o(tin), .running_o(run), .parked_o(prk), .gpio_in_o(gin));
	rpts_host #(.QUIET_CYCLES(50), .FPARK_CYCLES(10)) u_rpts_host (
		.clk_i(clk_i), .srst_i(srst_i), .pins(ifc.host), .power_good_i(pg),
		.power_fail_i(pf), .eye_left_i(eye_l), .eye_load_i(eye_ld),
		.i2c_allowed_o(i2c), .power_off_ok_o(poff));
	rpts_sva u_rpts_sva (
		.clk_i(clk_i), .srst_i(srst_i), .power_on_reset_in_n(ifc.power_on_reset_in_n),
		.fast_mirror_park_n(ifc.fast_mirror_park_n),
		.manufacturing_test_enable(ifc.manufacturing_test_enable),
		.gpio_in(ifc.gpio_in), .gpio_oe(ifc.gpio_oe), .strap_oe(ifc.strap_oe),
		.serial_flash_oe(ifc.serial_flash_oe),
		.light_source_select_0(ifc.light_source_select_0),
		.light_source_select_1(ifc.light_source_select_1),
		.mirror_driver_enable(ifc.mirror_driver_enable), .host_irq_oe(ifc.host_irq_oe));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: pick = ifc.mirror_driver_enable;
			1: pick = poff;
			2: pick = i2c;
			default: pick = prk;
		endcase
	endfunction

	// inputs always change one time unit after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wait_for(input int s, input logic v, input int lim);
		int k;
		k = 0;
		while (pick(s) !== v && k < lim) begin
			step(1);
			k++;
		end
		chk("wait", 32'(pick(s)), 32'(v));
		if (pick(s) !== v)
			report_and_stop();
	endtask

	task automatic s_powerup();
		chk("flash_oe", ifc.serial_flash_oe, 0);
		chk("gpio_oe", ifc.gpio_oe, 0);
		chk("strap_oe", ifc.strap_oe, 0);
		chk("irq_oe", ifc.host_irq_oe, 0);
		chk("sel", {ifc.light_source_select_1, ifc.light_source_select_0}, 0);
		chk("mde", ifc.mirror_driver_enable, 0);
		pg = 1'b1;
		wait_for(0, 1'b1, 60);
		chk("irq", ifc.host_irq_out, 1);
		chk("run", run, 1);
		chk("tms", tms, 8'h21);
		chk("tm", tm, 1);
		chk("strap_oe_run", ifc.strap_oe, 8'hff);
		chk("gpio_oe_run", ifc.gpio_oe, 20'hf_feff);
		chk("gpio_out", ifc.gpio_out, 20'h5_a5a5);
		chk("gpio_in", gin, 20'h5_a5a5);
		chk("flash", {ifc.serial_flash_select_1, ifc.serial_flash_select_0,
			ifc.serial_flash_data_out, ifc.serial_flash_clock}, 4'ha);
		chk("trig_lo", ifc.strap_out[4], 0);
		chk("i2c_early", i2c, 0);
		wait_for(2, 1'b1, 60);
		trg = 1'b1;
		lsel = 2'b10;
		step(3);
		chk("trig_hi", ifc.strap_out[4], 1);
		chk("lsel", {ifc.light_source_select_1, ifc.light_source_select_0}, 2'b10);
	endtask

	task automatic s_stream();
		strm = 1'b1;
		eye_l = 1'b1;
		eye_ld = 1'b1;
		step(5);
		chk("eye_left", ifc.stereo_eye_select, 1);
		chk("trigger_input", tin, 1);
		strm = 1'b0;
		eye_l = 1'b0;
		step(4);
		chk("eye_right", ifc.stereo_eye_select, 0);
		chk("trigger_input_off", tin, 0);
		eye_ld = 1'b0;
		eye_l = 1'b1;
		step(2);
		chk("eye_hold", ifc.stereo_eye_select, 0);
	endtask

	task automatic s_fastpark();
		pf = 1'b1;
		step(6);
		chk("mde_fp", ifc.mirror_driver_enable, 0);
		chk("poff_early", poff, 0);
		wait_for(1, 1'b1, 30);
		wait_for(3, 1'b1, 900);
		pf = 1'b0;
		step(20);
		chk("mde_parking", ifc.mirror_driver_enable, 0);
		wait_for(0, 1'b1, 900);
	endtask

	task automatic s_npark();
		gpio_brd[8] = 1'b0;
		step(10);
		chk("mde_slow", ifc.mirror_driver_enable, 1);
		wait_for(0, 1'b0, 40);
		gpio_brd[8] = 1'b1;
		step(10);
		chk("mde_latched", ifc.mirror_driver_enable, 0);
		pg = 1'b0;
		strap_brd = 8'h00;
		step(8);
		pg = 1'b1;
		wait_for(0, 1'b1, 60);
		chk("tms_open", tms, 0);
		chk("tm_open", tm, 0);
	endtask

	initial begin
		srst_i = 1'b1;
		pg = 1'b0;
		pf = 1'b0;
		eye_l = 1'b0;
		eye_ld = 1'b0;
		strm = 1'b0;
		trg = 1'b0;
		lsel = 2'b00;
		gout = 20'h5_a5a5;
		goe = 20'hf_ffff;
		flash = 4'ha;
		gpio_brd = 20'hf_ffff;
		strap_brd = 8'h21;
		step(2);
		srst_i = 1'b0;
		step(6);
		s_powerup();
		s_stream();
		s_fastpark();
		s_npark();
		report_and_stop();
	end
endmodule
